// File: design/swd_pkg.sv
/*
  Constants, field layouts and types for the reset-and-watchdog supervisor.
  Assumes a 25 MHz system clock; all periods are derived as cycle counts.
*/
`default_nettype none
package swd_pkg;

  // ----------------------------------------------------------------
  // Clock and time scales
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  // Basic timeout and hold: 4.94 ms per nF of setting
  localparam int unsigned BASIC_SCALE_NS = 4_940_000;
  // Window maximum: 0.65 s per nF of setting
  localparam int unsigned WIN_SCALE_NS = 650_000_000;
  localparam logic [31:0] BASIC_CYC_PER_UNIT =
    32'(BASIC_SCALE_NS / CLK_PERIOD_NS);
  localparam logic [31:0] WIN_CYC_PER_UNIT =
    32'(WIN_SCALE_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Widths and multipliers
  // ----------------------------------------------------------------
  localparam int SET_W = 16;
  localparam int CNT_W = 48;
  localparam int ADDR_W = 12;
  localparam int EXTEND_SHIFT = 7;
  localparam logic [2:0] RATIO8_SHIFT = 3'h3;
  localparam logic [2:0] RATIO16_SHIFT = 3'h4;
  localparam logic [2:0] RATIO64_SHIFT = 3'h6;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_WDT_SET = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_HOLD_SET = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h00C;
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_SEL_A_BIT = 1;
  localparam int CTRL_SEL_B_BIT = 2;
  localparam int STAT_RESET_BIT = 0;
  localparam int STAT_WD_EN_BIT = 1;
  localparam int STAT_FAST_BIT = 2;
  localparam int STAT_SLOW_BIT = 3;
  localparam int STAT_TIMEOUT_BIT = 4;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [SET_W-1:0] WDT_SET_RST = 16'h0000;
  localparam logic [SET_W-1:0] HOLD_SET_RST = 16'h0001;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic window_select_b;
    logic window_select_a;
    logic extend_select;
  } ctrl_s;

  typedef struct packed {
    logic timeout;
    logic slow;
    logic fast;
  } fault_s;

  typedef enum logic {WD_IDLE, WD_RUN} wd_state_e;

endpackage : swd_pkg
`default_nettype wire

// File: design/swd_edge_detect.sv
/*
  Edge detector: one-cycle rise and fall pulses of a level input.
  Assumes the input is synchronous to sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module swd_edge_detect
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Level and its edges
  input wire logic level,
  output logic rise,
  output logic fall
);

  logic prev_reg;

  // ----------------------------------------------------------------
  // Previous level
  // ----------------------------------------------------------------
  // Low at reset so a high level never looks like a falling edge
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      prev_reg <= 1'b0;
    else if (clk_en)
      prev_reg <= level;
  end

  assign rise = clk_en & level & ~prev_reg;
  assign fall = clk_en & ~level & prev_reg;

endmodule : swd_edge_detect
`default_nettype wire

// File: design/swd_reset_hold.sv
/*
  Reset hold timer: active while a cause stands or a trigger hits,
  then for hold_cycles more. Assumes synchronous inputs.
*/
`timescale 1ns/1ns
`default_nettype none
module swd_reset_hold
  import swd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Causes
  input wire logic cause,
  input wire logic trigger,
  input wire logic [CNT_W-1:0] hold_cycles,
  // Result
  output logic reset_active
);

  logic [CNT_W-1:0] cnt_reg;

  // ----------------------------------------------------------------
  // Hold counter
  // ----------------------------------------------------------------
  // Starts active so power-up gets a full hold
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reset_active <= 1'b1;
      cnt_reg <= '0;
    end
    else if (clk_en)
    begin
      if (cause || trigger)
      begin
        reset_active <= 1'b1;
        cnt_reg <= '0;
      end
      else if (reset_active)
      begin
        // A zero hold still gives one cycle
        if (cnt_reg + 1'b1 >= hold_cycles)
          reset_active <= 1'b0;
        else
          cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule : swd_reset_hold
`default_nettype wire

// File: design/supervisor_watchdog_reset.sv
/*
  Reset-and-watchdog supervisor with an APB register slave.
  Assumes all pin inputs synchronous to sys_clk (25 MHz).
*/
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module supervisor_watchdog_reset
  import swd_pkg::*;
#(
  parameter bit WINDOWED = 1'b0,
  parameter logic [31:0] BASIC_CYC = BASIC_CYC_PER_UNIT,
  parameter logic [31:0] WIN_CYC = WIN_CYC_PER_UNIT
)
(
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset causes
  input wire logic supply_undervoltage,
  input wire logic aux_voltage_low,
  input wire logic manual_reset_n,
  // Processor side
  input wire logic watchdog_kick_input,
  output logic reset_out_n
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ctrl_s ctrl_reg;
  logic [SET_W-1:0] watchdog_timing_setting;
  logic [SET_W-1:0] reset_hold_setting;
  fault_s fault_reg;
  fault_s fault_now;
  logic [31:0] prdata_reg;
  logic [31:0] rd_data;
  logic mapped;
  logic setup_rd;
  logic wr_en;
  logic reset_active;
  logic reset_cause;
  logic wd_fault;
  logic kick_rise;
  logic kick_fall;
  logic ext_rise;
  logic ext_fall;
  logic ext_change;
  logic wd_enabled;
  logic [2:0] ratio_shift;
  logic [CNT_W-1:0] basic_period;
  logic [CNT_W-1:0] timeout_period;
  logic [CNT_W-1:0] window_max_period;
  logic [CNT_W-1:0] window_min_period;
  logic [CNT_W-1:0] reset_hold_period;
  logic [CNT_W-1:0] timer_reg;
  wd_state_e state_reg;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  always_comb
  begin
    mapped = 1'b1;
    rd_data = 32'h0000_0000;
    if (paddr == ADDR_CTRL)
      rd_data = {29'h0000_0000, ctrl_reg};
    else if (paddr == ADDR_WDT_SET)
      rd_data = {16'h0000, watchdog_timing_setting};
    else if (paddr == ADDR_HOLD_SET)
      rd_data = {16'h0000, reset_hold_setting};
    else if (paddr == ADDR_STATUS)
    begin
      rd_data[STAT_RESET_BIT] = reset_active;
      rd_data[STAT_WD_EN_BIT] = wd_enabled;
      rd_data[STAT_FAST_BIT] = fault_reg.fast;
      rd_data[STAT_SLOW_BIT] = fault_reg.slow;
      rd_data[STAT_TIMEOUT_BIT] = fault_reg.timeout;
    end
    else
      mapped = 1'b0;
  end

  // Frozen enable stalls the access phase rather than dropping it
  assign pready = psel & penable & clk_en;
  assign pslverr = pready & ~mapped;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr_en = pready & pwrite & mapped;
  assign prdata = prdata_reg;

  // Read data captured in the setup cycle
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      prdata_reg <= 32'h0000_0000;
    else if (clk_en && setup_rd)
      prdata_reg <= rd_data;
  end

  // ----------------------------------------------------------------
  // Control and settings registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_reg <= CTRL_RST;
    else if (wr_en && paddr == ADDR_CTRL)
    begin
      ctrl_reg.extend_select <= pwdata[CTRL_EXT_BIT];
      ctrl_reg.window_select_a <= pwdata[CTRL_SEL_A_BIT];
      ctrl_reg.window_select_b <= pwdata[CTRL_SEL_B_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      watchdog_timing_setting <= WDT_SET_RST;
    else if (wr_en && paddr == ADDR_WDT_SET)
      watchdog_timing_setting <= pwdata[SET_W-1:0];
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      reset_hold_setting <= HOLD_SET_RST;
    else if (wr_en && paddr == ADDR_HOLD_SET)
      reset_hold_setting <= pwdata[SET_W-1:0];
  end

  // ----------------------------------------------------------------
  // Sticky fault flags
  // ----------------------------------------------------------------
  // Write one to clear; a fault in the same cycle wins
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      fault_reg <= '0;
    else if (clk_en)
    begin
      if (wr_en && paddr == ADDR_STATUS)
      begin
        fault_reg.fast <= fault_now.fast
          | (fault_reg.fast & ~pwdata[STAT_FAST_BIT]);
        fault_reg.slow <= fault_now.slow
          | (fault_reg.slow & ~pwdata[STAT_SLOW_BIT]);
        fault_reg.timeout <= fault_now.timeout
          | (fault_reg.timeout & ~pwdata[STAT_TIMEOUT_BIT]);
      end
      else
        fault_reg <= fault_reg | fault_now;
    end
  end

  // ----------------------------------------------------------------
  // Period arithmetic
  // ----------------------------------------------------------------
  // settings times cycles per unit
  assign basic_period = CNT_W'(watchdog_timing_setting)
    * CNT_W'(BASIC_CYC);
  assign window_max_period = CNT_W'(watchdog_timing_setting)
    * CNT_W'(WIN_CYC);
  assign reset_hold_period = CNT_W'(reset_hold_setting)
    * CNT_W'(BASIC_CYC);

  assign timeout_period = ctrl_reg.extend_select
    ? (basic_period << EXTEND_SHIFT) : basic_period;

  always_comb
  begin
    case ({ctrl_reg.window_select_a, ctrl_reg.window_select_b})
      2'b00: ratio_shift = RATIO8_SHIFT;
      2'b01: ratio_shift = RATIO16_SHIFT;
      2'b11: ratio_shift = RATIO64_SHIFT;
      default: ratio_shift = 3'h0;
    endcase
  end

  // minimum is the maximum over the strapped ratio
  assign window_min_period = window_max_period >> ratio_shift;

  // zero setting disables; strap code disables
  assign wd_enabled = (watchdog_timing_setting != '0)
    && !(WINDOWED && ctrl_reg.window_select_a
    && !ctrl_reg.window_select_b);

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  swd_edge_detect u_kick_edge
  (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .level(watchdog_kick_input),
    .rise(kick_rise),
    .fall(kick_fall)
  );

  swd_edge_detect u_ext_edge
  (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .level(ctrl_reg.extend_select),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  assign ext_change = ext_rise | ext_fall;

  // ----------------------------------------------------------------
  // Fault detection
  // ----------------------------------------------------------------
  // Evaluated only while running, so reset-time kicks never count
  // kicks ignored in reset
  always_comb
  begin
    fault_now = '0;
    if (state_reg == WD_RUN && !reset_active && wd_enabled)
    begin
      if (WINDOWED)
      begin
        // too early or too late
        // Timer trails the kick gap by one cycle
        if (kick_fall
          && timer_reg + 1'b1 < window_min_period)
          fault_now.fast = 1'b1;
        else if (!kick_fall && timer_reg + 1'b1 >= window_max_period)
          fault_now.slow = 1'b1;
      end
      else if (!kick_rise && !kick_fall && !ext_change
        && timer_reg + 1'b1 >= timeout_period)
        fault_now.timeout = 1'b1;
    end
  end

  assign wd_fault = |fault_now;

  // ----------------------------------------------------------------
  // Watchdog timer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= WD_IDLE;
      timer_reg <= '0;
    end
    else if (clk_en)
    begin
      case (state_reg)
        WD_IDLE:
        begin
          timer_reg <= '0;
          if (!reset_active && wd_enabled)
            state_reg <= WD_RUN;
        end
        default:
        begin
          // reset or fault clears and idles the timer
          if (reset_active || wd_fault || !wd_enabled)
          begin
            state_reg <= WD_IDLE;
            timer_reg <= '0;
          end
          // valid falling kick restarts the window
          else if (WINDOWED && kick_fall)
            timer_reg <= '0;
          // any kick edge; extend select change
          else if (!WINDOWED && (kick_rise || kick_fall || ext_change))
            timer_reg <= '0;
          else
            timer_reg <= timer_reg + 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Reset output
  // ----------------------------------------------------------------
  // level causes
  assign reset_cause = supply_undervoltage | aux_voltage_low
    | ~manual_reset_n;

  // hold after causes clear; fault pulse of hold length
  swd_reset_hold u_hold
  (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .cause(reset_cause),
    .trigger(wd_fault),
    .hold_cycles(reset_hold_period),
    .reset_active(reset_active)
  );

  // kicks have no effect while this is low
  assign reset_out_n = ~reset_active;

endmodule : supervisor_watchdog_reset
`default_nettype wire

// File: tb/swd_checker_sva.sv
/* Port assertions for the supervisor.
   Assumes a bind onto supervisor_watchdog_reset and clk_en held high. */
`timescale 1ns/1ns
`default_nettype none
module swd_checker
  import swd_pkg::*;
#(
  parameter logic [31:0] BASIC_CYC = 32'h0000_000A
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Causes and reset out
  input wire logic supply_undervoltage,
  input wire logic aux_voltage_low,
  input wire logic manual_reset_n,
  input wire logic reset_out_n
);
  // ----------------------------------------------------------------
  // Helper and assertions
  // ----------------------------------------------------------------
  logic cause_any;
  logic [31:0] clear_reg;
  assign cause_any = supply_undervoltage | aux_voltage_low | ~manual_reset_n;

  // Saturates, so a long quiet run never wraps
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
      clear_reg <= 32'h0000_0000;
    else if (cause_any)
      clear_reg <= 32'h0000_0000;
    else if (clk_en && clear_reg != 32'hFFFF_FFFF)
      clear_reg <= clear_reg + 32'h0000_0001;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  chk_supply_asserts: assert property (
    clk_en && supply_undervoltage |=> !reset_out_n)
    else $error("reset high after undervoltage");
  chk_aux_asserts: assert property (
    clk_en && aux_voltage_low |=> !reset_out_n)
    else $error("reset high after aux flag");
  chk_manual_asserts: assert property (
    clk_en && !manual_reset_n |=> !reset_out_n)
    else $error("reset high after manual reset");
  chk_hold_before_release: assert property (
    $rose(reset_out_n) |-> clear_reg >= BASIC_CYC - 32'h0000_0001)
    else $error("reset released before hold ran out");
  chk_pulse_min_length: assert property (
    $fell(reset_out_n) |-> !reset_out_n [*8])
    else $error("reset pulse too short");
  chk_ready_no_wait: assert property (
    clk_en && psel && penable |-> pready)
    else $error("pready missing in access cycle");
  chk_ready_only_access: assert property (
    pready |-> psel && penable)
    else $error("pready outside access cycle");
  chk_error_unmapped: assert property (
    pready && paddr > ADDR_STATUS |-> pslverr)
    else $error("no error on unmapped address");
  chk_error_mapped: assert property (
    pready && paddr <= ADDR_STATUS && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped address");
endmodule : swd_checker
`default_nettype wire

// File: tb/swd_processor_model.sv
/* Processor model: toggles the kick line, pauses while held in reset.
   Assumes one clock shared with the supervisor. */
`timescale 1ns/1ns
`default_nettype none
module swd_processor_model
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic reset_in_n,
  // Kick control
  input wire logic run,
  input wire logic [7:0] half,
  output logic kick
);
  // ----------------------------------------------------------------
  // Kick generator
  // ----------------------------------------------------------------
  logic [7:0] cnt_reg;

  // toggle every half cycles
  // A core in reset runs no code, so the line stands still
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
    begin
      cnt_reg <= 8'h00;
      kick <= 1'b0;
    end
    else if (!reset_in_n || !run)
      cnt_reg <= 8'h00;
    else if (cnt_reg + 8'h01 >= half)
    begin
      cnt_reg <= 8'h00;
      kick <= ~kick;
    end
    else
      cnt_reg <= cnt_reg + 8'h01;
endmodule : swd_processor_model
`default_nettype wire

// File: tb/tb_supervisor_watchdog_reset.sv
/* Bench: single and windowed variants share APB, causes and kick.
   Assumes shortened cycle counts and the processor model. */
`timescale 1ns/1ns
`default_nettype none
module tb_supervisor_watchdog_reset
  import swd_pkg::*;
();
  // ----------------------------------------------------------------
  // Signals, instances, tasks
  // ----------------------------------------------------------------
  localparam logic [31:0] BASIC = 32'h0000_000A;
  localparam int H = 10;
  logic sys_clk = 1'b0, arst_n = 1'b1, clk_en = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, rst_n, win_rst_n, kick;
  logic sup = 1'b0, aux = 1'b0, mr_n = 1'b1, run = 1'b0;
  logic [7:0] half = 8'h0A;
  logic [1:0] low_seen = 2'b00;
  int mismatches = 0, comparisons = 0;
  logic [31:0] cv [5] = '{32'h0, 32'h4, 32'h6, 32'h4, 32'h2};
  logic [7:0] hv [5] = '{8'h05, 8'h05, 8'h03, 8'h03, 8'h01};
  logic fv [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

  always #20 sys_clk = ~sys_clk;

  supervisor_watchdog_reset #(.WINDOWED(1'b0), .BASIC_CYC(BASIC),
    .WIN_CYC(32'h0000_0040)) dut_u (.sys_clk(sys_clk), .arst_n(arst_n),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .supply_undervoltage(sup), .aux_voltage_low(aux),
    .manual_reset_n(mr_n), .watchdog_kick_input(kick), .reset_out_n(rst_n));
  supervisor_watchdog_reset #(.WINDOWED(1'b1), .BASIC_CYC(BASIC),
    .WIN_CYC(32'h0000_0040)) win_u (.sys_clk(sys_clk), .arst_n(arst_n),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .supply_undervoltage(sup), .aux_voltage_low(aux),
    .manual_reset_n(mr_n), .watchdog_kick_input(kick),
    .reset_out_n(win_rst_n));
  swd_processor_model cpu_u (.sys_clk(sys_clk), .arst_n(arst_n),
    .reset_in_n(win_rst_n), .run(run), .half(half), .kick(kick));

  // Sampled on the falling edge, away from the bench's clears
  always @(negedge sys_clk)
  begin
    if (rst_n !== 1'b1)
      low_seen[0] = 1'b1;
    if (win_rst_n !== 1'b1)
      low_seen[1] = 1'b1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge sys_clk);
    end
    if (pready !== 1'b1)
      mismatches++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x,
    input logic ex);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    check(q, x);
    check({31'h0, e}, {31'h0, ex});
  endtask : rd_chk

  task automatic wait_val(input logic w, input logic v, input int lim,
    output int n);
    n = 0;
    while ((w ? win_rst_n : rst_n) !== v && n < lim)
    begin
      n++;
      @(posedge sys_clk);
    end
    if ((w ? win_rst_n : rst_n) !== v)
      mismatches++;
  endtask : wait_val

  task automatic restart(input logic [31:0] ctrl);
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    wr(ADDR_WDT_SET, 32'h0000_0002);
    wr(ADDR_CTRL, ctrl);
  endtask : restart

  task automatic final_report();
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    final_report();
  end

  initial
  begin
    int n;
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd_chk(ADDR_STATUS, 32'h0000_0001, 1'b0);
    rd_chk(ADDR_CTRL, 32'h0000_0000, 1'b0);
    rd_chk(ADDR_WDT_SET, 32'h0000_0000, 1'b0);
    rd_chk(ADDR_HOLD_SET, 32'h0000_0001, 1'b0);
    rd_chk(12'h010, 32'h0000_0000, 1'b1);
    wr(ADDR_HOLD_SET, 32'h0000_0002);
    rd_chk(ADDR_HOLD_SET, 32'h0000_0002, 1'b0);
    wr(ADDR_HOLD_SET, 32'h0000_0001);
    wait_val(1'b0, 1'b1, 60, n);
    for (int i = 0; i < 3; i++)
    begin
      sup <= (i == 0);
      aux <= (i == 1);
      mr_n <= (i != 2);
      repeat (3) @(posedge sys_clk);
      check(rst_n, 1'b0);
      sup <= 1'b0;
      aux <= 1'b0;
      mr_n <= 1'b1;
      repeat (H) @(posedge sys_clk);
      check(rst_n, 1'b0);
      @(posedge sys_clk);
      check(rst_n, 1'b1);
    end
    low_seen = 2'b00;
    repeat (100) @(posedge sys_clk);
    check(low_seen, 2'b00);
    run <= 1'b1;
    restart(32'h0000_0000);
    wait_val(1'b1, 1'b1, 60, n);
    low_seen = 2'b00;
    repeat (300) @(posedge sys_clk);
    check(low_seen, 2'b00);
    run <= 1'b0;
    wait_val(1'b0, 1'b0, 40, n);
    check(n inside {[10:23]}, 1'b1);
    wait_val(1'b0, 1'b1, 40, n);
    check(n, H);
    rd_chk(ADDR_STATUS, 32'h0000_0012, 1'b0);
    wait_val(1'b1, 1'b0, 200, n);
    check(n > 40, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      half <= hv[i];
      run <= 1'b1;
      restart(cv[i]);
      wait_val(1'b1, 1'b1, 60, n);
      low_seen = 2'b00;
      repeat (100) @(posedge sys_clk);
      check(low_seen[1], fv[i]);
    end
    run <= 1'b0;
    restart(32'h0000_0003);
    wait_val(1'b0, 1'b1, 60, n);
    low_seen = 2'b00;
    repeat (300) @(posedge sys_clk);
    check(low_seen[1], 1'b0);
    check(low_seen[0], 1'b0);
    wr(ADDR_CTRL, 32'h0000_0002);
    wait_val(1'b0, 1'b0, 60, n);
    check(n inside {[15:25]}, 1'b1);
    wr(ADDR_STATUS, 32'h0000_0010);
    rd_chk(ADDR_STATUS, 32'h0000_0003, 1'b0);
    final_report();
  end
endmodule : tb_supervisor_watchdog_reset

bind supervisor_watchdog_reset swd_checker #(.BASIC_CYC(BASIC_CYC)) chk_u (
  .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .supply_undervoltage(supply_undervoltage),
  .aux_voltage_low(aux_voltage_low), .manual_reset_n(manual_reset_n),
  .reset_out_n(reset_out_n));
`default_nettype wire
